/* File: include/lstog_pkg.sv */
// package for the local safe-torque-off gate: timing constants, states and carriers
package lstog_pkg;
	localparam int CLK_HZ = 50_000_000;
	// tolerated low test pulse width, in microseconds
	localparam int PULSE_MAX_US = 300;
	// least spacing between tolerated test pulses, in milliseconds
	localparam int GAP_MIN_MS = 200;
	// longest time rounds down
	localparam int PULSE_MAX_CYC = (CLK_HZ / 1_000_000) * PULSE_MAX_US;
	// least time rounds down as well
	localparam int GAP_MIN_CYC = (CLK_HZ / 1000) * GAP_MIN_MS;
	localparam int CNT_W = 24;

	typedef enum logic [1:0] {
		LSTOG_OFF = 2'b00,
		LSTOG_ON = 2'b01,
		LSTOG_PULSE = 2'b11
	} lstog_state_t;

	typedef struct packed {
		logic torque_allowed;
		logic torque_off_indication;
	} lstog_out_t;
endpackage

/* File: logic/lstog_gate.sv */
// local safe-torque-off gate: pulse filter on the release input and torque gating
// What this block does
// - torque only with release input and string enable
// - global string stop kept out of gating
// - release removed before a full gap has passed means torque cut at once
// - ignore short, widely spaced low test pulses
// - other pulses are real removals, torque off
// - drive enable refused while torque off active
`timescale 1ns/1ns
module lstog_gate #(
	parameter int PULSE_CYC = lstog_pkg::PULSE_MAX_CYC,
	parameter int GAP_CYC = lstog_pkg::GAP_MIN_CYC
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_torque_release_input,
	input wire logic i_string_hardware_enable,
	input wire logic i_drive_enable,
	output logic o_torque_allowed,
	output logic o_torque_off_indication
);
	// counters cannot serve a gap wider than their width or a gap not longer than a pulse
	if (PULSE_CYC < 1 || GAP_CYC <= PULSE_CYC || GAP_CYC >= (1 << lstog_pkg::CNT_W)) begin : g_bad_timing
		$error("lstog_gate: bad filter timing parameters");
	end

	localparam logic [lstog_pkg::CNT_W-1:0] PULSE_LIM = lstog_pkg::CNT_W'(PULSE_CYC);
	localparam logic [lstog_pkg::CNT_W-1:0] GAP_LIM = lstog_pkg::CNT_W'(GAP_CYC);
	localparam logic [lstog_pkg::CNT_W-1:0] CNT_ONE = lstog_pkg::CNT_W'(1);
	localparam logic [lstog_pkg::CNT_W-1:0] CNT_ZERO = '0;

	logic rel_s;
	logic str_s;
	logic drv_s;

	lstog_sync u_rel (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_torque_release_input),
		.o_sync(rel_s)
	);
	lstog_sync u_str (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_string_hardware_enable),
		.o_sync(str_s)
	);
	lstog_sync u_drv (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_async(i_drive_enable),
		.o_sync(drv_s)
	);

	lstog_pkg::lstog_state_t state_r;
	lstog_pkg::lstog_state_t state_nxt;
	logic [lstog_pkg::CNT_W-1:0] pulse_cnt_r;
	logic [lstog_pkg::CNT_W-1:0] pulse_cnt_nxt;
	// cycles since the last fresh release or tolerated pulse ended; saturates at the gap limit
	logic [lstog_pkg::CNT_W-1:0] gap_cnt_r;
	logic [lstog_pkg::CNT_W-1:0] gap_cnt_nxt;
	lstog_pkg::lstog_out_t out_r;
	lstog_pkg::lstog_out_t out_nxt;
	logic released;

	// filter: the state machine only widens the released window over a pulse
	always_comb begin
		state_nxt = state_r;
		pulse_cnt_nxt = pulse_cnt_r;
		gap_cnt_nxt = gap_cnt_r;
		if (gap_cnt_r != GAP_LIM)
			gap_cnt_nxt = gap_cnt_r + CNT_ONE;
		case (state_r)
			lstog_pkg::LSTOG_OFF: begin
				pulse_cnt_nxt = CNT_ZERO;
				// first pulse after a fresh release is not tolerated until a full gap passed
				if (rel_s) begin
					state_nxt = lstog_pkg::LSTOG_ON;
					gap_cnt_nxt = CNT_ZERO;
				end
			end
			lstog_pkg::LSTOG_ON: begin
				pulse_cnt_nxt = CNT_ZERO;
				if (!rel_s) begin
					if (gap_cnt_r == GAP_LIM) begin
						state_nxt = lstog_pkg::LSTOG_PULSE;
						pulse_cnt_nxt = CNT_ONE;
					end else begin
						state_nxt = lstog_pkg::LSTOG_OFF;
					end
				end
			end
			lstog_pkg::LSTOG_PULSE: begin
				if (rel_s) begin
					state_nxt = lstog_pkg::LSTOG_ON;
					gap_cnt_nxt = CNT_ZERO;
				end else if (pulse_cnt_r >= PULSE_LIM) begin
					state_nxt = lstog_pkg::LSTOG_OFF;
				end else begin
					pulse_cnt_nxt = pulse_cnt_r + CNT_ONE;
				end
			end
			default: begin
				state_nxt = lstog_pkg::LSTOG_OFF;
				pulse_cnt_nxt = CNT_ZERO;
			end
		endcase
	end

	// only the local input, the string enable and the drive enable steer gating, nothing global
	always_comb begin
		released = (state_nxt != lstog_pkg::LSTOG_OFF);
		out_nxt.torque_allowed = released && str_s && drv_s;
		out_nxt.torque_off_indication = !released;
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_r <= lstog_pkg::LSTOG_OFF;
			pulse_cnt_r <= CNT_ZERO;
			gap_cnt_r <= CNT_ZERO;
			out_r <= '{torque_allowed: 1'b0, torque_off_indication: 1'b1};
		end else begin
			state_r <= state_nxt;
			pulse_cnt_r <= pulse_cnt_nxt;
			gap_cnt_r <= gap_cnt_nxt;
			out_r <= out_nxt;
		end
	end

	assign o_torque_allowed = out_r.torque_allowed;
	assign o_torque_off_indication = out_r.torque_off_indication;
endmodule // lstog_gate

/* File: logic/lstog_sync.sv */
// two-flop synchroniser for a pin level
`timescale 1ns/1ns
module lstog_sync (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_async,
	output logic o_sync
);
	logic meta_r;
	logic meta_nxt;
	logic sync_r;
	logic sync_nxt;

	always_comb begin
		meta_nxt = i_async;
		sync_nxt = meta_r;
	end

	// reset low so the stage starts in the safe, torque-off reading
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end else begin
			meta_r <= meta_nxt;
			sync_r <= sync_nxt;
		end
	end

	assign o_sync = sync_r;
endmodule // lstog_sync

/* File: sim/lstog_gate_properties.sv */
// assertions on the gate ports
`timescale 1ns/1ns
module lstog_chk #(parameter int PULSE_CYC = 10, parameter int GAP_CYC = 100) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_torque_release_input,
	input wire logic i_string_hardware_enable,
	input wire logic i_drive_enable,
	input wire logic o_torque_allowed,
	input wire logic o_torque_off_indication
);
	int lo_cnt = 0;
	int hi_cnt = 0;
	always_ff @(posedge i_clk) begin
		lo_cnt <= i_torque_release_input ? 0 : lo_cnt + 1;
		hi_cnt <= i_torque_release_input ? hi_cnt + 1 : 0;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	sequence s_all_on;
		(i_torque_release_input && i_string_hardware_enable && i_drive_enable)[*5];
	endsequence
	property p_gate; o_torque_allowed |-> !o_torque_off_indication; endproperty
	a_gate: assert property (p_gate) else $error("torque with indication");
	property p_need; o_torque_allowed |-> $past(i_string_hardware_enable, 3) && $past(i_drive_enable, 3); endproperty
	a_need: assert property (p_need) else $error("torque without enables");
	property p_rise; s_all_on |-> o_torque_allowed; endproperty
	a_rise: assert property (p_rise) else $error("torque not released");
	property p_cut; lo_cnt >= PULSE_CYC + 4 |-> !o_torque_allowed && o_torque_off_indication; endproperty
	a_cut: assert property (p_cut) else $error("long low kept torque");
	property p_tol; $fell(i_torque_release_input) && o_torque_allowed && hi_cnt >= GAP_CYC + 4 |-> o_torque_allowed[*8];
	endproperty
	a_tol: assert property (p_tol) else $error("test pulse cut torque");
	property p_near; $fell(i_torque_release_input) && hi_cnt < GAP_CYC |-> ##[1:5] !o_torque_allowed; endproperty
	a_near: assert property (p_near) else $error("close pulse ignored");
endmodule // lstog_chk
bind lstog_gate lstog_chk #(.PULSE_CYC(PULSE_CYC), .GAP_CYC(GAP_CYC)) u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
	.i_torque_release_input(i_torque_release_input), .i_string_hardware_enable(i_string_hardware_enable),
	.i_drive_enable(i_drive_enable), .o_torque_allowed(o_torque_allowed),
	.o_torque_off_indication(o_torque_off_indication));

/* File: sim/lstog_gate_test.sv */
// self-checking bench for the gate
`timescale 1ns/1ns
module lstog_gate_test;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic str = 1'b0;
	logic drv = 1'b0;
	logic rel;
	logic allowed;
	logic off_ind;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	always #10 i_clk = ~i_clk;
	lstog_safety_ctl P (.i_clk(i_clk), .o_torque_release_input(rel));
	lstog_gate #(.PULSE_CYC(10), .GAP_CYC(100)) DUT (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_torque_release_input(rel), .i_string_hardware_enable(str), .i_drive_enable(drv),
		.o_torque_allowed(allowed), .o_torque_off_indication(off_ind));
	task automatic chk(input string what, input logic seen, input logic exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		if (fail_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(negedge i_clk);
	endtask
	task automatic t_gate;
		P.set_out(1'b1);
		wait_n(5);
		chk("allowed", allowed, 1'b1);
		chk("indication", off_ind, 1'b0);
		str = 1'b0;
		wait_n(5);
		chk("allowed", allowed, 1'b0);
		chk("indication", off_ind, 1'b0);
		str = 1'b1;
		drv = 1'b0;
		wait_n(5);
		chk("allowed", allowed, 1'b0);
		drv = 1'b1;
		wait_n(5);
	endtask
	task automatic t_pulses;
		wait_n(110);
		P.pulse(5);
		wait_n(5);
		chk("allowed", allowed, 1'b1);
		P.pulse(5);
		chk("allowed", allowed, 1'b0);
		chk("indication", off_ind, 1'b1);
		wait_n(110);
		P.pulse(15);
		chk("allowed", allowed, 1'b0);
		wait_n(5);
		chk("allowed", allowed, 1'b1);
	endtask
	task automatic t_reset;
		i_sys_rst = 1'b1;
		wait_n(3);
		chk("allowed", allowed, 1'b0);
		chk("indication", off_ind, 1'b1);
		i_sys_rst = 1'b0;
		wait_n(1);
		chk("allowed", allowed, 1'b0);
		wait_n(4);
		chk("allowed", allowed, 1'b1);
		chk("indication", off_ind, 1'b0);
	endtask
	task automatic t_stop;
		drv = 1'b0;
		P.set_out(1'b0);
		wait_n(5);
		chk("indication", off_ind, 1'b1);
		drv = 1'b1;
		wait_n(5);
		chk("allowed", allowed, 1'b0);
	endtask
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 1000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		wait_n(10);
		i_sys_rst = 1'b0;
		str = 1'b1;
		drv = 1'b1;
		t_gate();
		t_pulses();
		t_reset();
		t_stop();
		report_and_stop();
	end
endmodule // lstog_gate_test

/* File: sim/lstog_safety_ctl.sv */
// model of the safety controller driving the release input
`timescale 1ns/1ns
module lstog_safety_ctl (
	input wire logic i_clk,
	output logic o_torque_release_input
);
	initial o_torque_release_input = 1'b0;
	task automatic set_out(input logic v);
		@(negedge i_clk);
		o_torque_release_input = v;
	endtask
	task automatic pulse(input int n);
		set_out(1'b0);
		repeat (n) @(negedge i_clk);
		o_torque_release_input = 1'b1;
	endtask
endmodule // lstog_safety_ctl
